// [rtl/ildag_top.sv]
// Integer load path: address generation, memory request, zero-extended register write-back
// Operation
// - Effective address uses exactly one mode: base+offset, base+index, or base alone.
// - Immediate mode sign-extends the 16-bit offset to 32 bits and adds base.
// - Immediate mode with base field zero uses constant zero as base.
// - Indexed mode adds base and index; base field zero contributes zero.
// - Indirect mode uses base contents; base field zero gives address zero.
// - Update form, base nonzero and not target: base gets address, target gets data.
// - Update form with base field zero writes the address into register zero.
// - Update form with base equal to target leaves loaded data there.
// - Byte loads put the byte in the low eight bits, rest zero.
// - Half-word loads put the half-word in the low sixteen bits, rest zero.
module ildag_top (
   input wire logic I_CLK,
   input wire logic I_RESETN,
   input wire logic I_REQ_VALID,
   input wire ildag_pkg::ildag_mode_t I_MODE,
   input wire ildag_pkg::ildag_size_t I_SIZE,
   input wire logic I_UPDATE,
   input wire logic [ildag_pkg::REG_W-1:0] I_BASE_FIELD,
   input wire logic [ildag_pkg::REG_W-1:0] I_INDEX_FIELD,
   input wire logic [ildag_pkg::REG_W-1:0] I_TARGET_FIELD,
   input wire logic [ildag_pkg::OFS_W-1:0] I_OFFSET,
   input wire logic I_MEM_ACK,
   input wire logic [ildag_pkg::XLEN-1:0] I_MEM_DATA,
   input wire logic I_GPR_WE,
   input wire logic [ildag_pkg::REG_W-1:0] I_GPR_WADDR,
   input wire logic [ildag_pkg::XLEN-1:0] I_GPR_WDATA,
   input wire logic [ildag_pkg::REG_W-1:0] I_RD_FIELD,
   output logic O_BUSY,
   output logic O_MEM_REQ,
   output logic [ildag_pkg::XLEN-1:0] O_MEM_ADDR,
   output ildag_pkg::ildag_size_t O_MEM_SIZE,
   output logic O_DONE,
   output logic [ildag_pkg::XLEN-1:0] O_EFF_ADDR,
   output logic [ildag_pkg::XLEN-1:0] O_LOAD_DATA,
   output logic [ildag_pkg::XLEN-1:0] O_RD_DATA
);
   import ildag_pkg::*;

   ildag_state_t state, next_state;
   ildag_mode_t mode_q, next_mode_q;
   ildag_size_t size_q, next_size_q;
   logic update_q, next_update_q;
   logic [REG_W-1:0] base_q, next_base_q;
   logic [REG_W-1:0] target_q, next_target_q;
   logic base_zero_q, next_base_zero_q;
   logic [XLEN-1:0] base_val_q, next_base_val_q;
   logic [XLEN-1:0] index_val_q, next_index_val_q;
   logic [OFS_W-1:0] offset_q, next_offset_q;
   logic [XLEN-1:0] eff_addr_q, next_eff_addr_q;
   logic next_busy, next_mem_req, next_done;
   logic [XLEN-1:0] next_mem_addr, next_eff_out, next_load_data, next_rd_data;
   ildag_size_t next_mem_size;
   logic [XLEN-1:0] gpr [NUM_GPR];
   logic [XLEN-1:0] next_gpr [NUM_GPR];
   logic [XLEN-1:0] load_ext;
   logic accept;

   ildag_ea_if ea_bus ();

   assign ea_bus.mode = mode_q;
   assign ea_bus.base_zero = base_zero_q;
   assign ea_bus.base_val = base_val_q;
   assign ea_bus.index_val = index_val_q;
   assign ea_bus.offset = offset_q;

   ildag_ea_gen u_ea_gen (
      .ea(ea_bus)
   );

   // Reserved mode is dropped; only the three address modes start a load
   assign accept = (state == ILDAG_IDLE) && I_REQ_VALID && (I_MODE != ILDAG_MODE_RSV);

   always_comb begin
      case (size_q)
         ILDAG_SIZE_BYTE: begin
            load_ext = {{(XLEN-BYTE_W){1'b0}}, I_MEM_DATA[BYTE_W-1:0]};
         end
         ILDAG_SIZE_HALF: begin
            load_ext = {{(XLEN-HALF_W){1'b0}}, I_MEM_DATA[HALF_W-1:0]};
         end
         default: begin
            load_ext = I_MEM_DATA;
         end
      endcase
   end

   always_comb begin
      next_state = state;
      next_mode_q = mode_q;
      next_size_q = size_q;
      next_update_q = update_q;
      next_base_q = base_q;
      next_target_q = target_q;
      next_base_zero_q = base_zero_q;
      next_base_val_q = base_val_q;
      next_index_val_q = index_val_q;
      next_offset_q = offset_q;
      next_eff_addr_q = eff_addr_q;
      next_mem_req = 1'b0;
      next_mem_addr = O_MEM_ADDR;
      next_mem_size = O_MEM_SIZE;
      next_done = 1'b0;
      next_eff_out = O_EFF_ADDR;
      next_load_data = O_LOAD_DATA;
      next_rd_data = gpr[I_RD_FIELD];
      next_gpr = gpr;
      // Outside writes lose to load write-back in the same cycle
      if (I_GPR_WE) begin
         next_gpr[I_GPR_WADDR] = I_GPR_WDATA;
      end
      case (state)
         ILDAG_IDLE: begin
            if (accept) begin
               next_mode_q = I_MODE;
               next_size_q = I_SIZE;
               next_update_q = I_UPDATE;
               next_base_q = I_BASE_FIELD;
               next_target_q = I_TARGET_FIELD;
               next_base_zero_q = (I_BASE_FIELD == GPR_ZERO_IDX);
               next_base_val_q = gpr[I_BASE_FIELD];
               next_index_val_q = gpr[I_INDEX_FIELD];
               next_offset_q = I_OFFSET;
               next_state = ILDAG_ISSUE;
            end
         end
         ILDAG_ISSUE: begin
            // Operands were latched a cycle earlier to keep the adder off the array read path
            next_eff_addr_q = ea_bus.eff_addr;
            next_mem_req = 1'b1;
            next_mem_addr = ea_bus.eff_addr;
            next_mem_size = size_q;
            next_state = ILDAG_WAIT;
         end
         ILDAG_WAIT: begin
            if (I_MEM_ACK) begin
               // Address write first so data wins when base equals target
               if (update_q) begin
                  next_gpr[base_q] = eff_addr_q;
               end
               next_gpr[target_q] = load_ext;
               next_load_data = load_ext;
               next_eff_out = eff_addr_q;
               next_done = 1'b1;
               next_state = ILDAG_IDLE;
            end
         end
         default: begin
            next_state = ILDAG_IDLE;
         end
      endcase
      next_busy = (next_state != ILDAG_IDLE);
   end

   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         state <= ILDAG_IDLE;
         mode_q <= ILDAG_MODE_IMM;
         size_q <= ILDAG_SIZE_BYTE;
         update_q <= 1'b0;
         base_q <= GPR_ZERO_IDX;
         target_q <= GPR_ZERO_IDX;
         base_zero_q <= 1'b1;
         base_val_q <= GPR_RESET_VAL;
         index_val_q <= GPR_RESET_VAL;
         offset_q <= '0;
         eff_addr_q <= ADDR_RESET_VAL;
         O_BUSY <= 1'b0;
         O_MEM_REQ <= 1'b0;
         O_MEM_ADDR <= ADDR_RESET_VAL;
         O_MEM_SIZE <= ILDAG_SIZE_BYTE;
         O_DONE <= 1'b0;
         O_EFF_ADDR <= ADDR_RESET_VAL;
         O_LOAD_DATA <= GPR_RESET_VAL;
         O_RD_DATA <= GPR_RESET_VAL;
         for (int i = 0; i < NUM_GPR; i++) begin
            gpr[i] <= GPR_RESET_VAL;
         end
      end else begin
         state <= next_state;
         mode_q <= next_mode_q;
         size_q <= next_size_q;
         update_q <= next_update_q;
         base_q <= next_base_q;
         target_q <= next_target_q;
         base_zero_q <= next_base_zero_q;
         base_val_q <= next_base_val_q;
         index_val_q <= next_index_val_q;
         offset_q <= next_offset_q;
         eff_addr_q <= next_eff_addr_q;
         O_BUSY <= next_busy;
         O_MEM_REQ <= next_mem_req;
         O_MEM_ADDR <= next_mem_addr;
         O_MEM_SIZE <= next_mem_size;
         O_DONE <= next_done;
         O_EFF_ADDR <= next_eff_out;
         O_LOAD_DATA <= next_load_data;
         O_RD_DATA <= next_rd_data;
         for (int i = 0; i < NUM_GPR; i++) begin
            gpr[i] <= next_gpr[i];
         end
      end
   end

   logic ack_taken;
   assign ack_taken = (state == ILDAG_WAIT) && I_MEM_ACK;

   a_mode_reserved_drop: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      (state == ILDAG_IDLE && I_REQ_VALID && I_MODE == ILDAG_MODE_RSV) |=> (state == ILDAG_IDLE && !O_MEM_REQ))
      else $error("reserved mode started a load");

   a_imm_offset_sum: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      (state == ILDAG_ISSUE && mode_q == ILDAG_MODE_IMM && !base_zero_q) |=>
      (O_MEM_REQ && O_MEM_ADDR == base_val_q + {{16{offset_q[15]}}, offset_q}))
      else $error("immediate address wrong");

   a_imm_base_zero: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      (state == ILDAG_ISSUE && mode_q == ILDAG_MODE_IMM && base_zero_q) |=>
      (O_MEM_ADDR == {{16{offset_q[15]}}, offset_q}))
      else $error("immediate address with zero base wrong");

   a_idx_sum: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      (state == ILDAG_ISSUE && mode_q == ILDAG_MODE_IDX) |=>
      (O_MEM_ADDR == (base_zero_q ? index_val_q : base_val_q + index_val_q)))
      else $error("indexed address wrong");

   a_ind_base_only: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      (state == ILDAG_ISSUE && mode_q == ILDAG_MODE_IND) |=>
      (O_MEM_ADDR == (base_zero_q ? 32'h00000000 : base_val_q)))
      else $error("indirect address wrong");

   a_upd_split_write: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      (ack_taken && update_q && !base_zero_q && base_q != target_q) |=>
      (gpr[base_q] == eff_addr_q && gpr[target_q] == $past(load_ext) && O_DONE))
      else $error("update write-back wrong");

   a_upd_zero_base: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      (ack_taken && update_q && base_zero_q && target_q != GPR_ZERO_IDX) |=>
      (gpr[0] == eff_addr_q && state == ILDAG_IDLE))
      else $error("zero base update did not reach register zero");

   a_upd_same_reg: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      (ack_taken && update_q && base_q == target_q) |=> (gpr[target_q] == $past(load_ext)))
      else $error("base equal target kept address");

   a_byte_zero_ext: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      (ack_taken && size_q == ILDAG_SIZE_BYTE) |=>
      (O_LOAD_DATA[31:8] == 24'h000000 && O_LOAD_DATA[7:0] == $past(I_MEM_DATA[7:0])))
      else $error("byte load not zero extended");

   a_half_zero_ext: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      (ack_taken && size_q == ILDAG_SIZE_HALF) |=>
      (O_LOAD_DATA[31:16] == 16'h0000 && O_LOAD_DATA[15:0] == $past(I_MEM_DATA[15:0])))
      else $error("half-word load not zero extended");

   a_addr_wraps: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      (state == ILDAG_ISSUE && mode_q == ILDAG_MODE_IDX && !base_zero_q) |=>
      (O_MEM_ADDR == 32'({1'b0, base_val_q} + {1'b0, index_val_q})))
      else $error("address sum does not wrap");

   a_req_one_pulse: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      O_MEM_REQ |=> !O_MEM_REQ)
      else $error("memory request longer than one cycle");

   // Request goes out two cycles after accept: one to latch operands, one to add; busy is still high then
   a_req_after_accept: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      accept |-> ##2 (O_MEM_REQ && O_BUSY))
      else $error("request not issued two cycles after accept");

   a_busy_after_accept: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      accept |=> (O_BUSY && state == ILDAG_ISSUE))
      else $error("accepted load did not raise busy");

   a_done_one_pulse: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      O_DONE |=> !O_DONE)
      else $error("done longer than one cycle");

   a_done_after_ack: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      ack_taken |=> (O_DONE && !O_BUSY && O_EFF_ADDR == eff_addr_q))
      else $error("completion outputs wrong after answer");

   a_base_kept_plain: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      (ack_taken && !update_q && base_q != target_q && !(I_GPR_WE && I_GPR_WADDR == base_q)) |=>
      (gpr[base_q] == $past(gpr[base_q])))
      else $error("plain load changed its base register");

   a_word_unnarrowed: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      (ack_taken && size_q != ILDAG_SIZE_BYTE && size_q != ILDAG_SIZE_HALF) |=>
      (O_LOAD_DATA == $past(I_MEM_DATA)))
      else $error("word load was narrowed");

   c_imm_load: cover property (@(posedge I_CLK) disable iff (!I_RESETN)
      ack_taken && mode_q == ILDAG_MODE_IMM && size_q == ILDAG_SIZE_BYTE);
   c_idx_update: cover property (@(posedge I_CLK) disable iff (!I_RESETN)
      ack_taken && mode_q == ILDAG_MODE_IDX && update_q && base_q != target_q && !base_zero_q);
   c_same_reg: cover property (@(posedge I_CLK) disable iff (!I_RESETN)
      ack_taken && update_q && base_q == target_q);
   c_zero_base_upd: cover property (@(posedge I_CLK) disable iff (!I_RESETN)
      ack_taken && update_q && base_zero_q);
   c_reserved_drop: cover property (@(posedge I_CLK) disable iff (!I_RESETN)
      state == ILDAG_IDLE && I_REQ_VALID && I_MODE == ILDAG_MODE_RSV);
endmodule

// [rtl/ildag_pkg.sv]
// Shared constants and types for the integer load address generator
package ildag_pkg;
   localparam int XLEN = 32;
   localparam int REG_W = 5;
   localparam int NUM_GPR = 32;
   localparam int OFS_W = 16;
   localparam int BYTE_W = 8;
   localparam int HALF_W = 16;
   localparam logic [REG_W-1:0] GPR_ZERO_IDX = 5'h00;
   localparam logic [XLEN-1:0] GPR_RESET_VAL = 32'h00000000;
   localparam logic [XLEN-1:0] ADDR_RESET_VAL = 32'h00000000;

   typedef enum logic [1:0] {
      ILDAG_MODE_IMM,
      ILDAG_MODE_IDX,
      ILDAG_MODE_IND,
      ILDAG_MODE_RSV
   } ildag_mode_t;

   typedef enum logic [1:0] {
      ILDAG_SIZE_BYTE,
      ILDAG_SIZE_HALF,
      ILDAG_SIZE_WORD,
      ILDAG_SIZE_RSV
   } ildag_size_t;

   typedef enum logic [1:0] {
      ILDAG_IDLE,
      ILDAG_ISSUE,
      ILDAG_WAIT
   } ildag_state_t;
endpackage

// [rtl/ildag_ea_if.sv]
// Carrier between the load sequencer and the effective address generator
interface ildag_ea_if;
   import ildag_pkg::*;
   ildag_mode_t mode;
   logic base_zero;
   logic [XLEN-1:0] base_val;
   logic [XLEN-1:0] index_val;
   logic [OFS_W-1:0] offset;
   logic [XLEN-1:0] eff_addr;
   modport gen (input mode, input base_zero, input base_val, input index_val, input offset, output eff_addr);
   modport user (output mode, output base_zero, output base_val, output index_val, output offset, input eff_addr);
endinterface

// [rtl/ildag_ea_gen.sv]
// Effective address generator for the three addressing modes
module ildag_ea_gen (
   ildag_ea_if.gen ea
);
   import ildag_pkg::*;

   logic [XLEN-1:0] base_term;
   logic [XLEN-1:0] second_term;

   always_comb begin
      // Field zero means a literal zero, never register zero
      base_term = ea.base_zero ? '0 : ea.base_val;
      case (ea.mode)
         ILDAG_MODE_IMM: begin
            second_term = {{(XLEN-OFS_W){ea.offset[OFS_W-1]}}, ea.offset};
         end
         ILDAG_MODE_IDX: begin
            second_term = ea.index_val;
         end
         default: begin
            second_term = '0;
         end
      endcase
      // Same-width sum, carry out dropped
      ea.eff_addr = base_term + second_term;
   end
endmodule

// [testbench/ildag_mem_model.sv]
// Behavioural memory answering load requests after a chosen latency
module ildag_mem_model (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_mem_req,
   input wire logic [31:0] i_mem_addr,
   input wire logic [3:0] i_latency,
   output logic o_mem_ack,
   output logic [31:0] o_mem_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic pending;
   logic [3:0] cnt;
   logic [31:0] held_addr;
   // Upper bits carry junk so zero fill is really exercised
   function automatic logic [31:0] word_at(input logic [31:0] a);
      return {a[7:0], a[31:8]} ^ 32'hA5C3_3C5A;
   endfunction
   always @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pending <= 1'b0;
         cnt <= 4'h0;
         held_addr <= 32'h0000_0000;
         o_mem_ack <= 1'b0;
         o_mem_data <= 32'h5A5A_A5A5;
      end else begin
         o_mem_ack <= 1'b0;
         // Idle data toggles so a stale value never passes
         o_mem_data <= ~o_mem_data;
         if (pending) begin
            if (cnt == 4'h0) begin
               o_mem_ack <= 1'b1;
               o_mem_data <= word_at(held_addr);
               pending <= 1'b0;
            end else begin
               cnt <= cnt - 4'h1;
            end
         end else if (i_mem_req) begin
            if (i_latency <= 4'h1) begin
               o_mem_ack <= 1'b1;
               o_mem_data <= word_at(i_mem_addr);
            end else begin
               pending <= 1'b1;
               cnt <= i_latency - 4'h2;
               held_addr <= i_mem_addr;
            end
         end
      end
   end
endmodule

// [testbench/test_integer_load_addr_gen.sv]
// Self-checking bench for the integer load path
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin failures++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end
module test_integer_load_addr_gen
   import ildag_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, resetn, req_valid, update, mem_ack, gpr_we, busy, mem_req, done;
   ildag_mode_t mode;
   ildag_size_t size, mem_size;
   logic [4:0] base_f, index_f, target_f, gpr_waddr, rd_field;
   logic [15:0] offset;
   logic [31:0] mem_data, gpr_wdata, mem_addr, eff_addr, load_data, rd_data;
   logic [3:0] lat;
   logic [31:0] sh [32];
   int failures, total_checks, nreq;
   ildag_top u_ildag_top (.I_CLK(clk), .I_RESETN(resetn), .I_REQ_VALID(req_valid), .I_MODE(mode),
      .I_SIZE(size), .I_UPDATE(update), .I_BASE_FIELD(base_f), .I_INDEX_FIELD(index_f),
      .I_TARGET_FIELD(target_f), .I_OFFSET(offset), .I_MEM_ACK(mem_ack), .I_MEM_DATA(mem_data),
      .I_GPR_WE(gpr_we), .I_GPR_WADDR(gpr_waddr), .I_GPR_WDATA(gpr_wdata), .I_RD_FIELD(rd_field),
      .O_BUSY(busy), .O_MEM_REQ(mem_req), .O_MEM_ADDR(mem_addr), .O_MEM_SIZE(mem_size), .O_DONE(done),
      .O_EFF_ADDR(eff_addr), .O_LOAD_DATA(load_data), .O_RD_DATA(rd_data));
   ildag_mem_model u_ildag_mem_model (.i_clk(clk), .i_resetn(resetn), .i_mem_req(mem_req),
      .i_mem_addr(mem_addr), .i_latency(lat), .o_mem_ack(mem_ack), .o_mem_data(mem_data));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (mem_req === 1'b1) nreq++;
   end
   task automatic conclude();
      if (failures == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic wgpr(input logic [4:0] r, input logic [31:0] v);
      @(posedge clk);
      gpr_we <= 1'b1;
      gpr_waddr <= r;
      gpr_wdata <= v;
      @(posedge clk);
      gpr_we <= 1'b0;
      sh[r] = v;
   endtask
   task automatic rd_check(input logic [4:0] r);
      @(posedge clk);
      rd_field <= r;
      @(posedge clk);
      @(posedge clk);
      #1;
      `CHK(rd_data, sh[r])
   endtask
   task automatic load(input ildag_mode_t m, input ildag_size_t s, input logic u, input logic [4:0] b,
         input logic [4:0] x, input logic [4:0] t, input logic [15:0] o, input logic hold);
      logic [31:0] ea;
      logic [31:0] d;
      int n0;
      int k;
      ea = (b == 5'h00) ? 32'h0000_0000 : sh[b];
      if (m == ILDAG_MODE_IMM) ea = ea + {{16{o[15]}}, o};
      else if (m == ILDAG_MODE_IDX) ea = ea + sh[x];
      d = u_ildag_mem_model.word_at(ea);
      if (s == ILDAG_SIZE_BYTE) d = d & 32'h0000_00FF;
      else if (s == ILDAG_SIZE_HALF) d = d & 32'h0000_FFFF;
      n0 = nreq;
      @(posedge clk);
      req_valid <= 1'b1;
      mode <= m;
      size <= s;
      update <= u;
      base_f <= b;
      index_f <= x;
      target_f <= t;
      offset <= o;
      @(posedge clk);
      // Fields moved after the accept edge must not leak in
      offset <= ~o;
      req_valid <= hold;
      k = 0;
      do begin @(posedge clk); #1; k++; end while (mem_req !== 1'b1 && k < 10);
      `CHK(mem_addr, ea)
      `CHK(mem_size, s)
      `CHK(busy, 1'b1)
      @(posedge clk);
      req_valid <= 1'b0;
      k = 0;
      do begin @(posedge clk); #1; k++; end while (done !== 1'b1 && k < 40);
      `CHK(eff_addr, ea)
      `CHK(load_data, d)
      `CHK(nreq, n0 + 1)
      `CHK(busy, 1'b0)
      if (u) sh[b] = ea;
      sh[t] = d;
      if (u) rd_check(b);
      rd_check(t);
   endtask
   task automatic t_update();
      lat = 4'h1;
      load(ILDAG_MODE_IMM, ILDAG_SIZE_WORD, 1'b1, 5'h03, 5'h01, 5'h07, 16'h0010, 1'b0);
      load(ILDAG_MODE_IDX, ILDAG_SIZE_BYTE, 1'b1, 5'h00, 5'h05, 5'h09, 16'h0000, 1'b0);
      load(ILDAG_MODE_IMM, ILDAG_SIZE_HALF, 1'b1, 5'h0C, 5'h01, 5'h0C, 16'h8000, 1'b0);
   endtask
   task automatic t_immediate();
      lat = 4'h4;
      load(ILDAG_MODE_IMM, ILDAG_SIZE_BYTE, 1'b0, 5'h02, 5'h01, 5'h04, 16'h7FF0, 1'b0);
      load(ILDAG_MODE_IMM, ILDAG_SIZE_BYTE, 1'b0, 5'h00, 5'h01, 5'h06, 16'h8004, 1'b0);
   endtask
   task automatic t_indexed();
      lat = 4'h2;
      load(ILDAG_MODE_IDX, ILDAG_SIZE_HALF, 1'b0, 5'h08, 5'h0A, 5'h0B, 16'h0000, 1'b0);
      load(ILDAG_MODE_IDX, ILDAG_SIZE_HALF, 1'b0, 5'h00, 5'h0A, 5'h0D, 16'h0000, 1'b0);
   endtask
   task automatic t_indirect();
      load(ILDAG_MODE_IND, ILDAG_SIZE_WORD, 1'b0, 5'h0E, 5'h01, 5'h0F, 16'h1234, 1'b0);
      load(ILDAG_MODE_IND, ILDAG_SIZE_BYTE, 1'b0, 5'h00, 5'h01, 5'h10, 16'h1234, 1'b0);
      // Reserved size code must behave as a full word
      load(ILDAG_MODE_IND, ILDAG_SIZE_RSV, 1'b0, 5'h13, 5'h01, 5'h14, 16'h0000, 1'b0);
   endtask
   task automatic t_refused();
      int n0;
      n0 = nreq;
      @(posedge clk);
      req_valid <= 1'b1;
      mode <= ILDAG_MODE_RSV;
      @(posedge clk);
      req_valid <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      `CHK({busy, nreq}, {1'b0, n0})
      lat = 4'h6;
      load(ILDAG_MODE_IDX, ILDAG_SIZE_BYTE, 1'b0, 5'h04, 5'h07, 5'h11, 16'h0000, 1'b1);
   endtask
   // Generous against the few hundred cycles the tests need
   initial begin
      #50000;
      failures++;
      conclude();
   end
   initial begin
      {resetn, req_valid, update, gpr_we} = 4'h0;
      {base_f, index_f, target_f, gpr_waddr, rd_field} = 25'h0;
      {offset, gpr_wdata} = 48'h0;
      mode = ILDAG_MODE_IMM;
      size = ILDAG_SIZE_BYTE;
      lat = 4'h1;
      failures = 0;
      total_checks = 0;
      nreq = 0;
      sh[0] = 32'h0000_0000;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      // Bases near the top of memory so sums wrap
      for (int r = 1; r < 32; r++) wgpr(5'(r), 32'hFFFF_0000 | (32'(r) << 4));
      t_update();
      t_immediate();
      t_indexed();
      t_indirect();
      t_refused();
      conclude();
   end
endmodule
